// ==== src/nvic_pkg.sv ====
// constants for the nested vectored interrupt controller
// assumes one core clock and an active-low asynchronous reset
// Function
// - low-latency exception and interrupt handover to core
// - 85 maskable channels plus 16 core exceptions
// - 3-bit programmable priority, 8 levels
// - supply monitor on channel 1, vector 0x44
// - tamper timestamp on channel 2, vector 0x48
// - rtc wakeup on channel 3, vector 0x4C
// - flash global request on channel 4, vector 0x50
// - both converter units share channel 18
// - external lines 5 to 9 merge into 23
// - external lines 10 to 15 merge into 40
// - timer trigger and timer fourteen share 45
// - pending service exception programmable, vector 0x38
package nvic_pkg;
    localparam int CHAN_COUNT     = 85;
    localparam int CORE_EXC_COUNT = 16;
    localparam int EXC_COUNT      = CORE_EXC_COUNT + CHAN_COUNT;
    localparam int EXC_NUM_BITS   = 7;
    localparam int PRIO_BITS      = 3;
    localparam int RANK_BITS      = 4;
    localparam int SYS_PRIO_COUNT = 7;
    localparam int NEST_DEPTH     = 12;
    localparam int DEPTH_BITS     = 4;

    // ranks: lower wins; fixed levels sit above programmable ones
    localparam logic [RANK_BITS-1:0] RANK_RESET      = 4'h0;
    localparam logic [RANK_BITS-1:0] RANK_NMI        = 4'h1;
    localparam logic [RANK_BITS-1:0] RANK_HARD_FAULT = 4'h2;
    localparam logic [RANK_BITS-1:0] RANK_PROG_BASE  = 4'h3;
    localparam logic [RANK_BITS-1:0] RANK_IDLE       = 4'hF;

    // core exception numbers; vector slot is four times the number
    localparam int EXC_RESET      = 1;
    localparam int EXC_NMI        = 2;
    localparam int EXC_HARD_FAULT = 3;
    localparam int EXC_MEM_FAULT  = 4;
    localparam int EXC_BUS_FAULT  = 5;
    localparam int EXC_USAGE      = 6;
    localparam int EXC_SVCALL     = 11;
    localparam int EXC_DEBUG_MON  = 12;
    localparam int EXC_PEND_SVC   = 14;
    localparam int EXC_SYSTICK    = 15;

    // system priority slots within sys_priority
    localparam int SP_MEM = 0;
    localparam int SP_BUS = 1;
    localparam int SP_USAGE = 2;
    localparam int SP_SVCALL = 3;
    localparam int SP_DEBUG = 4;
    localparam int SP_PEND_SVC = 5;
    localparam int SP_SYSTICK = 6;

    // channel numbers of dedicated and merged sources
    localparam int CH_SUPPLY_MON   = 1;
    localparam int CH_TAMPER       = 2;
    localparam int CH_RTC_WAKEUP   = 3;
    localparam int CH_FLASH        = 4;
    localparam int CH_EXT_LINE0    = 6;
    localparam int CH_CONVERTER    = 18;
    localparam int CH_EXT_9_5      = 23;
    localparam int CH_EXT_15_10    = 40;
    localparam int CH_TIMER_SHARED = 45;
    localparam int EXT_LINE_COUNT  = 16;
    localparam int EXT_DIRECT      = 5;

    localparam logic [31:0] VEC_SLOT_BYTES = 32'h0000_0004;
endpackage : nvic_pkg

// ==== src/nvic_controller.sv ====
// nested vectored interrupt controller core
// assumes requests synchronous to clock, core acks one exception per cycle at most
`timescale 1ns/1ps
`default_nettype none
module nvic_controller
    import nvic_pkg::*;
(
    input  wire logic                               clock,
    input  wire logic                               nrst,
    input  wire logic [CHAN_COUNT-1:0]              irq_line,
    input  wire logic [CHAN_COUNT-1:0]              irq_enable,
    input  wire logic [CHAN_COUNT*PRIO_BITS-1:0]    irq_priority,
    input  wire logic                               supply_voltage_monitor,
    input  wire logic                               tamper_timestamp_request,
    input  wire logic                               rtc_wakeup_request,
    input  wire logic                               flash_global_request,
    input  wire logic [1:0]                         converter_request,
    input  wire logic [EXT_LINE_COUNT-1:0]          external_irq_line,
    input  wire logic                               second_advanced_timer_trg_com,
    input  wire logic                               general_timer_fourteen,
    input  wire logic                               nmi_request,
    input  wire logic                               hard_fault_exception,
    input  wire logic                               mem_fault_request,
    input  wire logic                               bus_fault_request,
    input  wire logic                               usage_fault_request,
    input  wire logic                               svcall_request,
    input  wire logic                               debug_monitor_request,
    input  wire logic                               pending_service_exception,
    input  wire logic                               systick_request,
    input  wire logic [SYS_PRIO_COUNT*PRIO_BITS-1:0] sys_priority,
    input  wire logic                               exc_ack,
    input  wire logic                               exc_return,
    output logic                                    exc_req,
    output logic [31:0]                             exc_vector,
    output logic [EXC_NUM_BITS-1:0]                 exc_number,
    output logic [RANK_BITS-1:0]                    exc_rank,
    output logic [RANK_BITS-1:0]                    active_rank,
    output logic                                    wakeup_event
);

    // programmable priority field to rank
    function automatic logic [RANK_BITS-1:0] prog_rank(input logic [PRIO_BITS-1:0] p);
        prog_rank = RANK_PROG_BASE + {1'b0, p};
    endfunction : prog_rank

    // exception number to vector address
    function automatic logic [31:0] vector_of(input logic [EXC_NUM_BITS-1:0] e);
        vector_of = VEC_SLOT_BYTES * {25'h0, e};
    endfunction : vector_of

    logic [EXC_COUNT-1:0]          req_all;
    logic [EXC_COUNT-1:0]          req_prev_reg;
    logic [EXC_COUNT-1:0]          pend_reg;
    logic [EXC_COUNT-1:0]          eligible;
    logic [RANK_BITS-1:0]          rank_of [EXC_COUNT];
    logic [CHAN_COUNT-1:0]         chan_req;
    logic                          reset_pend_reg;
    logic [RANK_BITS-1:0]          stack_reg [NEST_DEPTH];
    logic [DEPTH_BITS-1:0]         depth_reg;
    logic [RANK_BITS-1:0]          cur_rank;
    logic [RANK_BITS-1:0]          win_rank;
    logic [EXC_NUM_BITS-1:0]       win_num;
    logic                          win_valid;
    logic                          take;
    logic [RANK_BITS-1:0]          chan_rank [CHAN_COUNT];

    // channel request mapping, merged channels OR their sources
    always_comb
    begin
        chan_req                  = irq_line;
        chan_req[CH_SUPPLY_MON]   = supply_voltage_monitor;
        chan_req[CH_TAMPER]       = tamper_timestamp_request;
        chan_req[CH_RTC_WAKEUP]   = rtc_wakeup_request;
        chan_req[CH_FLASH]        = flash_global_request;
        chan_req[CH_CONVERTER]    = |converter_request;
        chan_req[CH_EXT_9_5]      = |external_irq_line[9:5];
        chan_req[CH_EXT_15_10]    = |external_irq_line[15:10];
        chan_req[CH_TIMER_SHARED] = second_advanced_timer_trg_com
                                  | general_timer_fourteen;
        for (int i = 0; i < EXT_DIRECT; i++)
        begin
            chan_req[CH_EXT_LINE0+i] = external_irq_line[i];
        end
    end

    // full exception request vector indexed by exception number
    always_comb
    begin
        req_all                 = '0;
        req_all[EXC_NMI]        = nmi_request;
        req_all[EXC_HARD_FAULT] = hard_fault_exception;
        req_all[EXC_MEM_FAULT]  = mem_fault_request;
        req_all[EXC_BUS_FAULT]  = bus_fault_request;
        req_all[EXC_USAGE]      = usage_fault_request;
        req_all[EXC_SVCALL]     = svcall_request;
        req_all[EXC_DEBUG_MON]  = debug_monitor_request;
        req_all[EXC_PEND_SVC]   = pending_service_exception;
        req_all[EXC_SYSTICK]    = systick_request;
        req_all[EXC_COUNT-1:CORE_EXC_COUNT] = chan_req;
    end

    // per-channel rank from its own priority field
    for (genvar n = 0; n < CHAN_COUNT; n++)
    begin : g_chan_rank
        assign chan_rank[n] = prog_rank(irq_priority[n*PRIO_BITS +: PRIO_BITS]);
    end

    // rank per exception number
    always_comb
    begin
        for (int e = 0; e < EXC_COUNT; e++)
        begin
            rank_of[e] = RANK_IDLE;
        end
        rank_of[EXC_RESET]      = RANK_RESET;
        rank_of[EXC_NMI]        = RANK_NMI;
        rank_of[EXC_HARD_FAULT] = RANK_HARD_FAULT;
        rank_of[EXC_MEM_FAULT]  = prog_rank(sys_priority[SP_MEM*PRIO_BITS +: PRIO_BITS]);
        rank_of[EXC_BUS_FAULT]  = prog_rank(sys_priority[SP_BUS*PRIO_BITS +: PRIO_BITS]);
        rank_of[EXC_USAGE]      = prog_rank(sys_priority[SP_USAGE*PRIO_BITS +: PRIO_BITS]);
        rank_of[EXC_SVCALL]     = prog_rank(sys_priority[SP_SVCALL*PRIO_BITS +: PRIO_BITS]);
        rank_of[EXC_DEBUG_MON]  = prog_rank(sys_priority[SP_DEBUG*PRIO_BITS +: PRIO_BITS]);
        rank_of[EXC_PEND_SVC]   =
            prog_rank(sys_priority[SP_PEND_SVC*PRIO_BITS +: PRIO_BITS]);
        rank_of[EXC_SYSTICK]    = prog_rank(sys_priority[SP_SYSTICK*PRIO_BITS +: PRIO_BITS]);
        for (int n = 0; n < CHAN_COUNT; n++)
        begin
            rank_of[CORE_EXC_COUNT+n] = chan_rank[n];
        end
    end

    // pending and enabled sources take part in arbitration
    always_comb
    begin
        eligible            = pend_reg;
        eligible[EXC_RESET] = reset_pend_reg;
        eligible[EXC_COUNT-1:CORE_EXC_COUNT] =
            pend_reg[EXC_COUNT-1:CORE_EXC_COUNT] & irq_enable;
    end

    // current running level from nesting stack
    always_comb
    begin
        cur_rank = RANK_IDLE;
        if (depth_reg != '0)
        begin
            cur_rank = stack_reg[depth_reg - 4'h1];
        end
    end

    // lowest rank wins, lower exception number breaks ties
    always_comb
    begin
        win_rank = RANK_IDLE;
        win_num  = '0;
        for (int e = EXC_COUNT - 1; e >= 0; e--)
        begin
            if (eligible[e] && (rank_of[e] <= win_rank))
            begin
                win_rank = rank_of[e];
                win_num  = EXC_NUM_BITS'(e);
            end
        end
        win_valid = (|eligible) && (win_rank < cur_rank);
    end

    assign take = exc_ack && exc_req;

    // edge capture of requests
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            req_prev_reg <= '0;
        end
        else
        begin
            req_prev_reg <= req_all;
        end
    end

    // sticky pending bits; a new edge wins over the ack clear
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            pend_reg <= '0;
        end
        else
        begin
            for (int e = 0; e < EXC_COUNT; e++)
            begin
                if (req_all[e] && !req_prev_reg[e])
                begin
                    pend_reg[e] <= 1'b1;
                end
                else if (take && (exc_number == EXC_NUM_BITS'(e)))
                begin
                    pend_reg[e] <= 1'b0;
                end
            end
        end
    end

    // reset exception pending from reset until taken
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            reset_pend_reg <= 1'b1;
        end
        else if (take && (exc_number == EXC_NUM_BITS'(EXC_RESET)))
        begin
            reset_pend_reg <= 1'b0;
        end
    end

    // nesting stack of active ranks
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            depth_reg <= '0;
            for (int i = 0; i < NEST_DEPTH; i++)
            begin
                stack_reg[i] <= RANK_IDLE;
            end
        end
        else if (take && exc_return && (depth_reg != '0))
        begin
            stack_reg[depth_reg - 4'h1] <= exc_rank;
        end
        else if (take && (depth_reg < DEPTH_BITS'(NEST_DEPTH)))
        begin
            stack_reg[depth_reg] <= exc_rank;
            depth_reg            <= depth_reg + 4'h1;
        end
        else if (exc_return && (depth_reg != '0))
        begin
            depth_reg <= depth_reg - 4'h1;
        end
    end

    // request flag; dropped the cycle after a take or a return
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            exc_req <= 1'b0;
        end
        else
        begin
            exc_req <= win_valid && !take && !exc_return;
        end
    end

    // presented vector, number and rank of the winner
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            exc_vector <= '0;
            exc_number <= '0;
            exc_rank   <= RANK_IDLE;
        end
        else
        begin
            exc_vector <= vector_of(win_num);
            exc_number <= win_num;
            exc_rank   <= win_rank;
        end
    end

    // power-management wake on any eligible request
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            wakeup_event <= 1'b0;
        end
        else
        begin
            wakeup_event <= |eligible;
        end
    end

    // running level, one cycle behind the stack
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            active_rank <= RANK_IDLE;
        end
        else
        begin
            active_rank <= cur_rank;
        end
    end

endmodule : nvic_controller
`default_nettype wire

// ==== verif/nvic_properties.sv ====
// port assertions for the interrupt controller
// assumes a bind onto nvic_controller, one clock domain
`timescale 1ns/1ps
`default_nettype none
module nvic_properties
    import nvic_pkg::*;
(
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic [84:0] irq_enable,
    input wire logic        supply_voltage_monitor,
    input wire logic        rtc_wakeup_request,
    input wire logic        exc_ack,
    input wire logic        exc_return,
    input wire logic        exc_req,
    input wire logic [31:0] exc_vector,
    input wire logic [6:0]  exc_number,
    input wire logic [3:0]  exc_rank,
    input wire logic [3:0]  active_rank,
    input wire logic        wakeup_event
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence supply_rise;
        $rose(supply_voltage_monitor) && irq_enable[1] && active_rank == 4'hF && !exc_req;
    endsequence
    sequence taken_now;
        exc_req && exc_ack;
    endsequence
    a_vector_slot: assert property (
        exc_req |-> exc_vector == {23'h0, exc_number, 2'h0})
        else $error("vector is not four times the number");
    a_req_holds: assert property (
        exc_req && !exc_ack && !exc_return |=> exc_req && $stable(exc_vector))
        else $error("presented vector moved before ack");
    a_ack_drops: assert property (taken_now |=> !exc_req)
        else $error("request stayed up after ack");
    a_fixed_rank: assert property (
        exc_req && exc_number <= 7'h3 |-> exc_rank == 4'(exc_number - 7'h1))
        else $error("fixed exception has wrong rank");
    a_prog_rank: assert property (
        exc_req && exc_number > 7'h3 |-> exc_rank inside {[4'h3:4'hA]})
        else $error("programmable rank out of range");
    a_supply_latency: assert property (supply_rise |-> ##[1:2] exc_req)
        else $error("supply request not presented in time");
    a_wake_flag: assert property (
        $rose(rtc_wakeup_request) && irq_enable[3] |-> ##[1:2] wakeup_event)
        else $error("wakeup event missing");
    a_active_rank: assert property (taken_now |=> ##1 active_rank == $past(exc_rank, 2))
        else $error("active rank does not follow taken exception");
endmodule : nvic_properties
bind nvic_controller nvic_properties i_props (.clock(clock), .nrst(nrst),
    .irq_enable(irq_enable), .supply_voltage_monitor(supply_voltage_monitor),
    .rtc_wakeup_request(rtc_wakeup_request), .exc_ack(exc_ack), .exc_return(exc_return),
    .exc_req(exc_req), .exc_vector(exc_vector), .exc_number(exc_number),
    .exc_rank(exc_rank), .active_rank(active_rank), .wakeup_event(wakeup_event));
`default_nettype wire

// ==== verif/nvic_core_model.sv ====
// behavioural core: takes presented exceptions and retires them
// assumes bench inputs change at the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module nvic_core_model
(
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        exc_req,
    input  wire logic [31:0] exc_vector,
    input  wire logic [6:0]  exc_number,
    input  wire logic [3:0]  exc_rank,
    input  wire logic        hold,
    input  wire logic [1:0]  delay,
    input  wire logic        chain,
    output logic             exc_ack,
    output logic             exc_return,
    output logic [31:0]      got_vec,
    output logic [6:0]       got_num,
    output logic [3:0]       got_rank,
    output var int           taken
);
    int wait_cnt;
    int returned;
    // fetch record at the ack edge
    always @(posedge clock)
        if (!nrst)
            taken <= 0;
        else if (exc_req && exc_ack)
        begin
            got_vec  <= exc_vector;
            got_num  <= exc_number;
            got_rank <= exc_rank;
            taken    <= taken + 1;
        end
    // one-cycle ack and return pulses
    always @(negedge clock)
        if (!nrst)
        begin
            exc_ack    <= 1'h0;
            exc_return <= 1'h0;
            wait_cnt   <= 0;
            returned   <= 0;
        end
        else
        begin
            exc_ack    <= 1'h0;
            exc_return <= 1'h0;
            if (exc_ack)
                wait_cnt <= 0;
            else if (taken > returned && !hold)
            begin
                exc_return <= 1'h1;
                returned   <= returned + 1;
            end
            else if (exc_req && wait_cnt >= int'(delay))
            begin
                exc_ack <= 1'h1;
                // tail-chain: finish the active one as the next is taken
                if (chain && taken > returned)
                begin
                    exc_return <= 1'h1;
                    returned   <= returned + 1;
                end
            end
            else if (exc_req)
                wait_cnt <= wait_cnt + 1;
        end
endmodule : nvic_core_model
`default_nettype wire

// ==== verif/nested_vector_irq_controller_tb.sv ====
// self-checking bench for the interrupt controller
// assumes nvic_core_model on the core side
`timescale 1ns/1ps
`default_nettype none
module nested_vector_irq_controller_tb
    import nvic_pkg::*;
;
    localparam int SRC_NUM [33] = '{17, 18, 19, 20, 34, 34, 22, 23, 24, 25, 26, 39, 39, 39, 39,
        39, 56, 56, 56, 56, 56, 56, 61, 61, 2, 3, 4, 5, 6, 11, 12, 14, 15};
    logic         clock = 1'h0;
    logic         nrst = 1'h0;
    logic [84:0]  irq_line = '0;
    logic [84:0]  irq_enable = '1;
    logic [254:0] irq_priority = '0;
    logic [20:0]  sys_priority = '0;
    logic [32:0]  src = '0;
    logic         hold = 1'h0;
    logic [1:0]   delay = 2'h0;
    logic         chain = 1'h0;
    logic         exc_ack, exc_return, exc_req, wakeup_event, first;
    logic [31:0]  exc_vector, got_vec;
    logic [6:0]   exc_number, got_num, na, nb;
    logic [3:0]   exc_rank, active_rank, got_rank;
    int           taken, ca, cb;
    int           seen = 0;
    int           num_errors = 0;
    int           compares = 0;
    always #4 clock = ~clock;
    nvic_controller i_dut (.clock(clock), .nrst(nrst), .irq_line(irq_line),
        .irq_enable(irq_enable), .irq_priority(irq_priority),
        .supply_voltage_monitor(src[0]), .tamper_timestamp_request(src[1]),
        .rtc_wakeup_request(src[2]), .flash_global_request(src[3]),
        .converter_request(src[5:4]), .external_irq_line(src[21:6]),
        .second_advanced_timer_trg_com(src[22]), .general_timer_fourteen(src[23]),
        .nmi_request(src[24]), .hard_fault_exception(src[25]), .mem_fault_request(src[26]),
        .bus_fault_request(src[27]), .usage_fault_request(src[28]), .svcall_request(src[29]),
        .debug_monitor_request(src[30]), .pending_service_exception(src[31]),
        .systick_request(src[32]), .sys_priority(sys_priority), .exc_ack(exc_ack),
        .exc_return(exc_return), .exc_req(exc_req), .exc_vector(exc_vector),
        .exc_number(exc_number), .exc_rank(exc_rank), .active_rank(active_rank),
        .wakeup_event(wakeup_event));
    nvic_core_model i_core (.clock(clock), .nrst(nrst), .exc_req(exc_req),
        .exc_vector(exc_vector), .exc_number(exc_number), .exc_rank(exc_rank), .hold(hold),
        .delay(delay), .chain(chain), .exc_ack(exc_ack), .exc_return(exc_return),
        .got_vec(got_vec), .got_num(got_num), .got_rank(got_rank), .taken(taken));
    function automatic logic [3:0] exp_rank(input logic [6:0] n);
        int s;
        if (n <= 7'h3)
            return 4'(n - 7'h1);
        if (n >= 7'h10)
            return 4'h3 + 4'(irq_priority[3*(n-16) +: 3]);
        s = (n <= 7'h6) ? int'(n) - 4 : (n == 7'hB) ? 3 : (n == 7'hC) ? 4 : (n == 7'hE) ? 5 : 6;
        return 4'h3 + 4'(sys_priority[3*s +: 3]);
    endfunction : exp_rank
    task automatic rand_prio();
        for (int c = 0; c < 85; c++)
            irq_priority[3*c +: 3] = 3'($urandom());
        sys_priority = 21'($urandom());
    endtask : rand_prio
    task automatic wait_take(input logic [6:0] n);
        for (int i = 0; i < 60 && taken == seen; i++)
            @(negedge clock);
        seen = seen + 1;
        compares = compares + 1;
        if (taken < seen || got_num !== n || got_vec !== {23'h0, n, 2'h0}
            || got_rank !== exp_rank(n))
        begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t take %0d got %0d vec %h", $time, n, got_num, got_vec);
            if (taken < seen)
                disable main;
        end
        repeat (4) @(negedge clock);
    endtask : wait_take
    task automatic check_none();
        repeat (12) @(negedge clock);
        compares = compares + 1;
        if (taken != seen)
        begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t unexpected exception %0d", $time, got_num);
            seen = taken;
        end
    endtask : check_none
    task automatic end_sim();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    initial
    begin
        void'($urandom(75426));
        begin : main
            repeat (20) @(negedge clock);
            nrst = 1'h1;
            wait_take(7'h1);
            $display("test reset done");
            for (int b = 0; b < 33; b++)
            begin
                src = '0;
                @(negedge clock);
                rand_prio();
                src = 33'h1 << b;
                wait_take(7'(SRC_NUM[b])); // slot map
            end
            src = '0;
            $display("test sources done");
            irq_enable[1] = 1'h0;
            src[0] = 1'h1;
            check_none();
            irq_enable[1] = 1'h1;
            wait_take(7'h11);
            src = '0;
            $display("test mask done");
            for (int k = 0; k < 10; k++)
            begin
                irq_line = '0;
                @(negedge clock);
                rand_prio();
                delay = 2'($urandom());
                ca = $urandom_range(39, 24);
                cb = $urandom_range(84, 46);
                if (k == 0)
                    irq_priority[3*cb +: 3] = irq_priority[3*ca +: 3];
                na = 7'(ca + 16);
                nb = 7'(cb + 16);
                first = exp_rank(na) <= exp_rank(nb);
                irq_line = (85'h1 << ca) | (85'h1 << cb);
                wait_take(first ? na : nb);
                wait_take(first ? nb : na);
            end
            irq_line = '0;
            $display("test order done");
            hold = 1'h1;
            irq_priority[33 +: 9] = 9'h0B5;
            irq_line[11] = 1'h1;
            wait_take(7'h1B);
            irq_line[12] = 1'h1;
            check_none();
            chain = 1'h1;
            irq_line[13] = 1'h1;
            wait_take(7'h1D);
            chain = 1'h0;
            hold = 1'h0;
            wait_take(7'h1C);
            irq_line = '0;
            $display("test nesting done");
        end
        end_sim();
    end
endmodule : nested_vector_irq_controller_tb
`default_nettype wire
